// [include/devcfg_pkg.sv]
package devcfg_pkg;

  // ---------------------------------------------------------------
  // Register selects on the configuration access port
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_DEVCAP = 2'h0;
  localparam logic [1:0] REG_DEVCTL = 2'h1;
  localparam logic [1:0] REG_DEVCAP2 = 2'h2;

  // Function select
  localparam logic FUNC_RP = 1'b0;
  localparam logic FUNC_EP = 1'b1;

  // ---------------------------------------------------------------
  // Device capability word fields
  // ---------------------------------------------------------------
  localparam int CAP_MPS_LSB = 0;
  localparam int CAP_PHANTOM_LSB = 3;
  localparam int CAP_EXT_TAG = 5;
  localparam int CAP_L0S_LSB = 6;
  localparam int CAP_L1_LSB = 9;
  localparam int CAP_ROLE_ERR = 15;
  localparam int CAP_PWR_VAL_LSB = 18;
  localparam int CAP_PWR_SCALE_LSB = 26;
  localparam int CAP_FLR = 28;

  // ---------------------------------------------------------------
  // Device control word fields
  // ---------------------------------------------------------------
  localparam int CTL_RO_EN = 4;
  localparam int CTL_PHANTOM_EN = 9;
  localparam int CTL_AUX_PM_EN = 10;
  localparam int CTL_NO_SNOOP_EN = 11;
  localparam int CTL_FLR = 15;
  localparam logic [15:0] CTL_RESET = 16'h2810;
  // Error enables, payload, tag, snoop, read size
  localparam logic [15:0] CTL_WMASK_BASE = 16'h79EF;
  localparam logic [15:0] CTL_RO_MASK = 16'h0010;

  // ---------------------------------------------------------------
  // Device capability word two fields
  // ---------------------------------------------------------------
  localparam int CAP2_CTO_RANGES_LSB = 0;
  localparam int CAP2_CTO_DIS = 4;
  localparam int CAP2_ARI_FWD = 5;
  localparam int CAP2_ATOMIC_ROUTE = 6;
  localparam int CAP2_ATOMIC32 = 7;
  localparam int CAP2_ATOMIC64 = 8;
  localparam int CAP2_CAS128 = 9;
  localparam int CAP2_NO_RO_PRPR = 10;
  localparam int CAP2_LTR = 11;
  localparam int CAP2_TPH_LSB = 12;
  localparam int CAP2_LN_CLS_LSB = 14;
  localparam int CAP2_TAG10_CPL = 16;
  localparam int CAP2_TAG10_REQ = 17;
  localparam int CAP2_OBFF_LSB = 18;
  localparam int CAP2_EXT_FMT = 20;
  localparam int CAP2_E2E_PFX = 21;
  localparam int CAP2_E2E_MAX_LSB = 22;
  localparam int CAP2_EPR_LSB = 24;
  localparam int CAP2_EPR_INIT = 26;
  localparam int CAP2_FRS = 31;

  // ---------------------------------------------------------------
  // Function level reset timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int FLR_TIME_MS = 100;
  localparam int FLR_CYCLES =
    FLR_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    FLR_IDLE = 1'b0,
    FLR_BUSY = 1'b1
  } flr_state_t;

endpackage

// [hw/devctl_store.sv]
`timescale 1ns/1ps
module devctl_store
  import devcfg_pkg::*;
#(
  parameter logic [15:0] WMASK = 16'h0000,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Function reset, back to defaults
  input wire logic func_rst,
  // Write strobe with byte lanes
  input wire logic wr_en,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  // Stored word
  output logic [15:0] ctl_q
);

  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic [15:0] lane_mask;

  // ----------------------------------------------------------------
  // Next value: only writable bits move, hardwired bits keep reset
  // ----------------------------------------------------------------
  always_comb begin
    lane_mask = {{8{wr_be[1]}}, {8{wr_be[0]}}} & WMASK;
    ctl_nxt = ctl_r;
    if (func_rst) begin
      ctl_nxt = RST_VAL;
    end else if (wr_en) begin
      ctl_nxt = (ctl_r & ~lane_mask) | (wr_data & lane_mask);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_r <= RST_VAL;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign ctl_q = ctl_r;

endmodule

// [hw/flr_sequencer.sv]
`timescale 1ns/1ps
module flr_sequencer
  import devcfg_pkg::*;
#(
  parameter int HOLD_CYCLES = FLR_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Start request, one cycle
  input wire logic flr_start,
  // Function held in reset while high
  output logic flr_active
);

  flr_state_t state_r;
  flr_state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  // ----------------------------------------------------------------
  // Hold the function in reset for the whole reset window; a new
  // start while busy is absorbed rather than restarting the count
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      FLR_IDLE: begin
        if (flr_start) begin
          state_nxt = FLR_BUSY;
          cnt_nxt = 32'(HOLD_CYCLES - 1);
        end
      end
      FLR_BUSY: begin
        if (cnt_r == 32'h0) begin
          state_nxt = FLR_IDLE;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= FLR_IDLE;
      cnt_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign flr_active = (state_r == FLR_BUSY);

endmodule

// [hw/integrated_dev_regs.sv]
`timescale 1ns/1ps
module integrated_dev_regs
  import devcfg_pkg::*;
#(
  // Implementation choices for both functions
  parameter logic [2:0] MPS_SUPPORTED = 3'h1,
  parameter logic [2:0] L0S_LATENCY = 3'h0,
  parameter logic [2:0] L1_LATENCY = 3'h0,
  // Endpoint abilities
  parameter logic EP_RO_CAPABLE = 1'b1,
  parameter logic EP_NEEDS_ARI = 1'b0,
  parameter logic EP_PEER_ATOMICS = 1'b0,
  parameter logic EP_ATOMIC_32_64 = 1'b0,
  parameter logic EP_CAS_128 = 1'b0,
  parameter logic EP_P2P_RO = 1'b0,
  parameter logic EP_LTR = 1'b0,
  parameter logic [1:0] EP_OBFF = 2'h0,
  parameter logic [1:0] EP_TPH = 2'h0,
  parameter logic [1:0] EP_LN_CLS = 2'h0,
  parameter logic EP_E2E_PFX = 1'b0,
  parameter logic [1:0] EP_E2E_MAX = 2'h0,
  parameter logic EP_FRS = 1'b0,
  parameter logic [3:0] EP_CTO_RANGES = 4'h0,
  parameter logic EP_CTO_DIS = 1'b0,
  // Root port forwarding involvement and its own timeout support
  parameter logic RP_FORWARDS = 1'b0,
  parameter logic [3:0] RP_CTO_RANGES = 4'h0,
  parameter logic RP_CTO_DIS = 1'b0,
  // Endpoint function reset window in clock cycles
  parameter int FLR_HOLD_CYCLES = FLR_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Configuration access port
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic cfg_func,
  input wire logic [1:0] cfg_reg,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic cfg_err,
  output logic [31:0] cfg_rdata,
  // Endpoint transaction attributes
  input wire logic ep_tx_valid,
  input wire logic ep_tx_ro_want,
  input wire logic ep_tx_ns_want,
  output logic ep_tx_attr_valid,
  output logic ep_tx_attr_ro,
  output logic ep_tx_attr_ns,
  // Endpoint function reset
  output logic ep_func_reset
);

  // ----------------------------------------------------------------
  // Per-function control write masks
  // ----------------------------------------------------------------
  // phantom and aux off
  localparam logic [15:0] RP_WMASK = CTL_WMASK_BASE | CTL_RO_MASK;
  localparam logic [15:0] EP_WMASK =
    EP_RO_CAPABLE ? (CTL_WMASK_BASE | CTL_RO_MASK) : CTL_WMASK_BASE;
  localparam logic [15:0] EP_RST_VAL =
    EP_RO_CAPABLE ? CTL_RESET : (CTL_RESET & ~CTL_RO_MASK);

  logic [31:0] devcap_w;
  logic [31:0] rp_cap2_w;
  logic [31:0] ep_cap2_w;
  logic [15:0] rp_ctl;
  logic [15:0] ep_ctl;
  logic ctl_wr;
  logic rp_ctl_wr;
  logic ep_ctl_wr;
  logic flr_start;
  logic flr_active;
  logic ack_r;
  logic ack_nxt;
  logic err_r;
  logic err_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic attr_v_r;
  logic attr_v_nxt;
  logic attr_ro_r;
  logic attr_ro_nxt;
  logic attr_ns_r;
  logic attr_ns_nxt;

  // ----------------------------------------------------------------
  // Device capability word, identical in both functions
  // ----------------------------------------------------------------
  always_comb begin
    devcap_w = 32'h0;
    devcap_w[CAP_MPS_LSB +: 3] = MPS_SUPPORTED;
    devcap_w[CAP_PHANTOM_LSB +: 2] = 2'h0;
    devcap_w[CAP_EXT_TAG] = 1'b1;
    devcap_w[CAP_L0S_LSB +: 3] = L0S_LATENCY;
    devcap_w[CAP_L1_LSB +: 3] = L1_LATENCY;
    devcap_w[CAP_ROLE_ERR] = 1'b1;
    devcap_w[CAP_PWR_VAL_LSB +: 8] = 8'h00;
    devcap_w[CAP_PWR_SCALE_LSB +: 2] = 2'h0;
    // Only the endpoint can act on function level reset
    devcap_w[CAP_FLR] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Endpoint capability word two
  // ----------------------------------------------------------------
  always_comb begin
    ep_cap2_w = 32'h0;
    ep_cap2_w[CAP2_CTO_RANGES_LSB +: 4] = EP_CTO_RANGES;
    ep_cap2_w[CAP2_CTO_DIS] = EP_CTO_DIS;
    ep_cap2_w[CAP2_LTR] = EP_LTR;
    ep_cap2_w[CAP2_OBFF_LSB +: 2] = EP_OBFF;
    ep_cap2_w[CAP2_TPH_LSB +: 2] = EP_TPH;
    ep_cap2_w[CAP2_TAG10_REQ] = 1'b1;
    ep_cap2_w[CAP2_EXT_FMT] = 1'b1;
    ep_cap2_w[CAP2_E2E_PFX] = EP_E2E_PFX;
    ep_cap2_w[CAP2_E2E_MAX_LSB +: 2] = EP_E2E_MAX;
    ep_cap2_w[CAP2_EPR_LSB +: 2] = 2'h0;
    ep_cap2_w[CAP2_EPR_INIT] = 1'b0;
    ep_cap2_w[CAP2_FRS] = EP_FRS;
  end

  // ----------------------------------------------------------------
  // Root port capability word two, mostly mirrored from the endpoint
  // ----------------------------------------------------------------
  always_comb begin
    rp_cap2_w = 32'h0;
    rp_cap2_w[CAP2_CTO_RANGES_LSB +: 4] =
      RP_FORWARDS ? RP_CTO_RANGES : 4'h0;
    rp_cap2_w[CAP2_CTO_DIS] = RP_FORWARDS ? RP_CTO_DIS : 1'b0;
    rp_cap2_w[CAP2_ARI_FWD] = EP_NEEDS_ARI;
    rp_cap2_w[CAP2_ATOMIC_ROUTE] = EP_PEER_ATOMICS;
    rp_cap2_w[CAP2_ATOMIC32] = EP_ATOMIC_32_64;
    rp_cap2_w[CAP2_ATOMIC64] = EP_ATOMIC_32_64;
    rp_cap2_w[CAP2_CAS128] = EP_CAS_128;
    rp_cap2_w[CAP2_NO_RO_PRPR] = EP_P2P_RO;
    rp_cap2_w[CAP2_LTR] = EP_LTR;
    rp_cap2_w[CAP2_TPH_LSB +: 2] = EP_TPH;
    rp_cap2_w[CAP2_LN_CLS_LSB +: 2] = EP_LN_CLS;
    rp_cap2_w[CAP2_TAG10_CPL] = 1'b1;
    rp_cap2_w[CAP2_TAG10_REQ] = 1'b1;
    rp_cap2_w[CAP2_OBFF_LSB +: 2] = EP_OBFF;
    rp_cap2_w[CAP2_EXT_FMT] = 1'b1;
    rp_cap2_w[CAP2_E2E_PFX] = EP_E2E_PFX;
    rp_cap2_w[CAP2_E2E_MAX_LSB +: 2] = EP_E2E_MAX;
    rp_cap2_w[CAP2_EPR_LSB +: 2] = 2'h0;
    rp_cap2_w[CAP2_EPR_INIT] = 1'b0;
    rp_cap2_w[CAP2_FRS] = EP_FRS;
  end

  // ----------------------------------------------------------------
  // Control word write decode
  // ----------------------------------------------------------------
  // Capability words are read only, so writes there are dropped
  // capability writes dropped
  assign ctl_wr = cfg_valid & cfg_write & (cfg_reg == REG_DEVCTL);
  assign rp_ctl_wr = ctl_wr & (cfg_func == FUNC_RP);
  // Writes to the endpoint are dropped while its reset window runs
  assign ep_ctl_wr = ctl_wr & (cfg_func == FUNC_EP) & ~flr_active;
  assign flr_start = ep_ctl_wr & cfg_be[1] & cfg_wdata[CTL_FLR];

  devctl_store #(
    .WMASK(RP_WMASK),
    .RST_VAL(CTL_RESET)
  ) u_rp_ctl (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .func_rst(1'b0),
    .wr_en(rp_ctl_wr),
    .wr_be(cfg_be[1:0]),
    .wr_data(cfg_wdata[15:0]),
    .ctl_q(rp_ctl)
  );

  devctl_store #(
    .WMASK(EP_WMASK),
    .RST_VAL(EP_RST_VAL)
  ) u_ep_ctl (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .func_rst(flr_active),
    .wr_en(ep_ctl_wr),
    .wr_be(cfg_be[1:0]),
    .wr_data(cfg_wdata[15:0]),
    .ctl_q(ep_ctl)
  );

  flr_sequencer #(
    .HOLD_CYCLES(FLR_HOLD_CYCLES)
  ) u_flr (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flr_start(flr_start),
    .flr_active(flr_active)
  );

  // ----------------------------------------------------------------
  // Read data and completion, one cycle after the request
  // ----------------------------------------------------------------
  always_comb begin
    ack_nxt = cfg_valid;
    err_nxt = 1'b0;
    rdata_nxt = 32'h0;
    if (cfg_valid) begin
      unique case (cfg_reg)
        REG_DEVCAP: begin
          rdata_nxt = devcap_w;
        end
        REG_DEVCTL: begin
          rdata_nxt = {16'h0000,
            ((cfg_func == FUNC_EP) ? ep_ctl : rp_ctl)};
        end
        REG_DEVCAP2: begin
          rdata_nxt = (cfg_func == FUNC_EP) ? ep_cap2_w : rp_cap2_w;
        end
        default: begin
          // Unmapped select reads zero and flags the access
          err_nxt = 1'b1;
        end
      endcase
      if (cfg_write) begin
        rdata_nxt = 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Endpoint transaction attributes
  // ----------------------------------------------------------------
  // Root port copies of these enables feed nothing on purpose
  // sizes and tag unused
  always_comb begin
    attr_v_nxt = ep_tx_valid & ~flr_active;
    attr_ro_nxt = attr_v_nxt & ep_tx_ro_want & ep_ctl[CTL_RO_EN];
    attr_ns_nxt = attr_v_nxt & ep_tx_ns_want & ep_ctl[CTL_NO_SNOOP_EN];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0;
      attr_v_r <= 1'b0;
      attr_ro_r <= 1'b0;
      attr_ns_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
      attr_v_r <= attr_v_nxt;
      attr_ro_r <= attr_ro_nxt;
      attr_ns_r <= attr_ns_nxt;
    end
  end

  assign cfg_ack = ack_r;
  assign cfg_err = err_r;
  assign cfg_rdata = rdata_r;
  assign ep_tx_attr_valid = attr_v_r;
  assign ep_tx_attr_ro = attr_ro_r;
  assign ep_tx_attr_ns = attr_ns_r;
  assign ep_func_reset = flr_active;

endmodule

// [bench/dev_regs_monitor.sv]
`timescale 1ns/1ps
module dev_regs_monitor
  import devcfg_pkg::*;
#(
  parameter int FLR_HOLD_CYCLES = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Configuration access port
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic cfg_func,
  input wire logic [1:0] cfg_reg,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic cfg_err,
  input wire logic [31:0] cfg_rdata,
  // Endpoint attributes and function reset
  input wire logic ep_tx_valid,
  input wire logic ep_tx_ro_want,
  input wire logic ep_tx_ns_want,
  input wire logic ep_tx_attr_valid,
  input wire logic ep_tx_attr_ro,
  input wire logic ep_tx_attr_ns,
  input wire logic ep_func_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Read qualifier shared by every register
  logic rd_q;
  assign rd_q = cfg_valid && !cfg_write;
  // Counts cycles the endpoint sits in function reset
  int flr_cnt_r;
  int flr_cnt_nxt;
  always_comb begin
    flr_cnt_nxt = ep_func_reset ? flr_cnt_r + 1 : 0;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flr_cnt_r <= 0;
    end else begin
      flr_cnt_r <= flr_cnt_nxt;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_ack;
    cfg_valid |=> cfg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_err;
    cfg_valid && cfg_reg == 2'h3 |=> cfg_err && cfg_rdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_cap;
    rd_q && cfg_reg == REG_DEVCAP |=> cfg_rdata[CAP_ROLE_ERR] &&
      cfg_rdata[CAP_EXT_TAG] && cfg_rdata[27:18] == 10'h0 &&
      cfg_rdata[4:3] == 2'h0;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability constant wrong");
  property p_ctl;
    rd_q && cfg_reg == REG_DEVCTL |=> !cfg_rdata[15] &&
      cfg_rdata[10:9] == 2'h0;
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("control zero bits set");
  property p_cap2;
    rd_q && cfg_reg == REG_DEVCAP2 && cfg_func == FUNC_RP |=>
      cfg_rdata[17:16] == 2'h3 && cfg_rdata[20] &&
      cfg_rdata[26:24] == 3'h0;
  endproperty
  a_cap2: assert property (p_cap2)
    else $error("capability two constant wrong");
  property p_flr_go;
    cfg_valid && cfg_write && cfg_func && cfg_reg == REG_DEVCTL &&
      cfg_be[1] && cfg_wdata[15] && !ep_func_reset |=> ep_func_reset;
  endproperty
  a_flr_go: assert property (p_flr_go)
    else $error("function reset not started");
  property p_flr_len;
    $fell(ep_func_reset) |-> flr_cnt_r == FLR_HOLD_CYCLES;
  endproperty
  a_flr_len: assert property (p_flr_len)
    else $error("function reset length wrong");
  property p_attr_off;
    ep_func_reset && $past(ep_func_reset) |->
      !ep_tx_attr_valid && !ep_tx_attr_ro && !ep_tx_attr_ns;
  endproperty
  a_attr_off: assert property (p_attr_off)
    else $error("attributes during reset");
  property p_attr_ro;
    ep_tx_attr_ro |-> ep_tx_attr_valid && $past(ep_tx_ro_want);
  endproperty
  a_attr_ro: assert property (p_attr_ro)
    else $error("relaxed ordering unasked");
  property p_attr_ns;
    ep_tx_attr_ns |-> ep_tx_attr_valid && $past(ep_tx_ns_want);
  endproperty
  a_attr_ns: assert property (p_attr_ns)
    else $error("no-snoop unasked");
  // Main scenarios reached
  c_flr: cover property ($rose(ep_func_reset));
  c_ro: cover property (ep_tx_attr_ro && ep_tx_attr_ns);
  c_err: cover property (cfg_err);
endmodule

bind integrated_dev_regs dev_regs_monitor #(
  .FLR_HOLD_CYCLES(FLR_HOLD_CYCLES)
) u_mon (
  .mclk(mclk), .sys_rst(sys_rst), .cfg_valid(cfg_valid),
  .cfg_write(cfg_write), .cfg_func(cfg_func), .cfg_reg(cfg_reg),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
  .cfg_err(cfg_err), .cfg_rdata(cfg_rdata), .ep_tx_valid(ep_tx_valid),
  .ep_tx_ro_want(ep_tx_ro_want), .ep_tx_ns_want(ep_tx_ns_want),
  .ep_tx_attr_valid(ep_tx_attr_valid), .ep_tx_attr_ro(ep_tx_attr_ro),
  .ep_tx_attr_ns(ep_tx_attr_ns), .ep_func_reset(ep_func_reset)
);

// [bench/integrated_dev_regs_bench.sv]
`timescale 1ns/1ps
module integrated_dev_regs_bench;
  import devcfg_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic mclk, sys_rst, cfg_valid, cfg_write, cfg_func, cfg_ack, cfg_err;
  logic [1:0] cfg_reg;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic ep_tx_valid, ep_tx_ro_want, ep_tx_ns_want, ep_func_reset;
  logic ep_tx_attr_valid, ep_tx_attr_ro, ep_tx_attr_ns;
  int fail_count, total_checks, cycles, n;
  // Short reset window keeps the run brief
  integrated_dev_regs #(
    .EP_NEEDS_ARI(1'b1), .EP_LTR(1'b1), .EP_OBFF(2'h2),
    .EP_E2E_PFX(1'b1),
    .FLR_HOLD_CYCLES(8)
  ) dut (
    .mclk(mclk), .sys_rst(sys_rst), .cfg_valid(cfg_valid),
    .cfg_write(cfg_write), .cfg_func(cfg_func), .cfg_reg(cfg_reg),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_err(cfg_err), .cfg_rdata(cfg_rdata), .ep_tx_valid(ep_tx_valid),
    .ep_tx_ro_want(ep_tx_ro_want), .ep_tx_ns_want(ep_tx_ns_want),
    .ep_tx_attr_valid(ep_tx_attr_valid), .ep_tx_attr_ro(ep_tx_attr_ro),
    .ep_tx_attr_ns(ep_tx_attr_ns), .ep_func_reset(ep_func_reset)
  );
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // One access; request held for exactly the taking edge
  task automatic acc(logic f, logic [1:0] r, logic w, logic [3:0] be,
                     logic [31:0] d);
    @(posedge mclk);
    cfg_valid <= 1'b1;
    cfg_func <= f;
    cfg_reg <= r;
    cfg_write <= w;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_valid <= 1'b0;
    #1;
    chk("ack", 32'h1, {31'h0, cfg_ack});
    rd = cfg_rdata;
  endtask
  task automatic rdc(string nm, logic f, logic [1:0] r, logic [31:0] m,
                     logic [31:0] e);
    acc(f, r, 1'b0, 4'hF, 32'h0);
    chk(nm, e, rd & m);
  endtask
  // One endpoint transaction; attributes seen a cycle later
  task automatic tx(logic ro, logic ns, logic [2:0] e);
    @(posedge mclk);
    ep_tx_valid <= 1'b1;
    ep_tx_ro_want <= ro;
    ep_tx_ns_want <= ns;
    @(posedge mclk);
    ep_tx_valid <= 1'b0;
    #1;
    chk("attr", {29'h0, e},
        {29'h0, ep_tx_attr_valid, ep_tx_attr_ro, ep_tx_attr_ns});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog and stimulus
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Whole sequence needs under a hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {sys_rst, cfg_valid, cfg_write, cfg_func} = 4'h8;
    {cfg_reg, cfg_be, cfg_wdata} = '0;
    {ep_tx_valid, ep_tx_ro_want, ep_tx_ns_want} = 3'h0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    // Capability words in both functions, writes refused
    for (int f = 0; f < 2; f++) begin
      rdc("cap", f[0], REG_DEVCAP, 32'h1FFC_8FFF, 32'h1000_8021);
      acc(f[0], REG_DEVCAP, 1'b1, 4'hF, 32'hFFFF_FFFF);
      rdc("cap", f[0], REG_DEVCAP, 32'h1FFC_8FFF, 32'h1000_8021);
      rdc("ctl", f[0], REG_DEVCTL, 32'hFFFF_FFFF, 32'h2810);
    end
    rdc("cap2", FUNC_RP, REG_DEVCAP2, 32'h87FF_0FFF, 32'h003B_0820);
    acc(FUNC_RP, REG_DEVCAP2, 1'b1, 4'hF, 32'h0);
    rdc("cap2", FUNC_RP, REG_DEVCAP2, 32'h87FF_0FFF, 32'h003B_0820);
    rdc("cap2e", FUNC_EP, REG_DEVCAP2, 32'h07FE_0800, 32'h003A_0800);
    // Root port control: zero bits stay zero, no function reset
    acc(FUNC_RP, REG_DEVCTL, 1'b1, 4'h3, 32'hFFFF);
    chk("rst", 32'h0, {31'h0, ep_func_reset});
    rdc("ctl", FUNC_RP, REG_DEVCTL, 32'hFFFF_FFFF, 32'h79FF);
    acc(FUNC_RP, REG_DEVCTL, 1'b1, 4'h1, 32'h0);
    rdc("ctl", FUNC_RP, REG_DEVCTL, 32'hFFFF_FFFF, 32'h7900);
    // Unmapped select
    acc(FUNC_RP, 2'h3, 1'b0, 4'hF, 32'h0);
    chk("err", 32'h1, {31'h0, cfg_err});
    // Endpoint attributes follow endpoint control only
    acc(FUNC_EP, REG_DEVCTL, 1'b1, 4'h3, 32'h71E0);
    tx(1'b1, 1'b1, 3'h4);
    acc(FUNC_RP, REG_DEVCTL, 1'b1, 4'h3, 32'h0810);
    tx(1'b1, 1'b1, 3'h4);
    acc(FUNC_EP, REG_DEVCTL, 1'b1, 4'h3, 32'h0810);
    tx(1'b1, 1'b1, 3'h7);
    tx(1'b0, 1'b1, 3'h5);
    tx(1'b1, 1'b0, 3'h6);
    // Endpoint function reset, write ignored during it
    acc(FUNC_EP, REG_DEVCTL, 1'b1, 4'h3, 32'h8000);
    chk("rst", 32'h1, {31'h0, ep_func_reset});
    tx(1'b1, 1'b1, 3'h0);
    acc(FUNC_EP, REG_DEVCTL, 1'b1, 4'h3, 32'h0);
    n = 0;
    // Sample the reset flag settled, not in the edge that moves it
    while (ep_func_reset && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("rst", 32'h0, {31'h0, ep_func_reset});
    rdc("ctl", FUNC_EP, REG_DEVCTL, 32'hFFFF_FFFF, 32'h2810);
    tx(1'b1, 1'b1, 3'h7);
    print_verdict();
  end
endmodule
